// ### src/esv_exception_unit.sv
/*
  esv_exception_unit: exception state tracking, prioritisation and vector
  address generation for a 32-bit microcontroller core.
  Assumes all inputs are synchronous to i_core_clk; the core pulses
  i_exc_return when the running handler completes and holds
  i_instr_boundary high when it can accept exception entry.
*/
`timescale 1ns/1ns

// Behaviour
// - each exception inactive, pending, active, or both
// - peripheral or software request makes interrupt pending
// - re-raise while active gives active and pending
// - handlers nest, all stay active
// - reset halts at once, number 1, priority -3
// - after reset fetch vector 0x4, privileged thread
// - nmi number 2, always enabled, priority -2
// - nothing masks nmi; only reset preempts it
// - hard fault on processing error or escalation
// - protection violation raises memory management fault
// - memory system error raises bus fault
// - usage fault on bad instruction or state
// - unaligned and divide traps only when configured
// - supervisor call instruction raises exception 11
// - deferred service request is software pended, 14
// - system tick on timer zero or software
// - interrupts 0-67 map to exceptions 16-83
// - asynchronous entry may wait one instruction
// - configurable exceptions can be disabled, fixed cannot
// - active field shows exception number
// - lower value wins; fixed negatives beat 0-15
// - equal priority: lowest exception number first
// - equal priority never preempts, only pends
module esv_exception_unit (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // interrupt and system event sources
  input wire logic [esv_pkg::NUM_IRQ-1:0] i_irq_req,
  input wire logic [esv_pkg::NUM_IRQ-1:0] i_irq_sw_set,
  input wire logic i_nmi_req,
  input wire logic i_nmi_sw_set,
  input wire logic i_dsr_sw_set,
  input wire logic i_tick_zero,
  input wire logic i_tick_sw_set,
  input wire logic i_svc_exec,
  // fault sources
  input wire logic i_exc_proc_err,
  input wire logic i_mpu_violation,
  input wire logic i_bus_err_precise,
  input wire logic i_bus_err_imprecise,
  input wire logic i_undef_instr,
  input wire logic i_illegal_unaligned,
  input wire logic i_invalid_state,
  input wire logic i_exc_return_err,
  input wire logic i_unaligned_access,
  input wire logic i_div_by_zero,
  // configuration
  input wire logic i_trap_unaligned_cfg,
  input wire logic i_trap_div0_cfg,
  input wire logic [esv_pkg::NUM_EXC-1:0] i_exc_enable,
  input wire logic [esv_pkg::NUM_EXC*esv_pkg::PRIO_W-1:0] i_exc_prio,
  // core handshake
  input wire logic i_instr_boundary,
  input wire logic i_exc_return,
  // entry and status
  output logic o_halt,
  output logic o_thread_priv,
  output logic o_take,
  output logic [esv_pkg::EXC_W-1:0] o_take_num,
  output logic [31:0] o_vector_addr,
  output logic [esv_pkg::ACT_W-1:0] o_active_num,
  output logic [esv_pkg::NUM_EXC-1:0] o_pending,
  output logic [esv_pkg::NUM_EXC-1:0] o_active
);

  function automatic logic is_reserved(input logic [esv_pkg::EXC_W-1:0] n);
    return (n == esv_pkg::EXC_NONE) || (n > esv_pkg::EXC_LAST) ||
           (n >= esv_pkg::EXC_RSV_A_LO && n <= esv_pkg::EXC_RSV_A_HI) ||
           (n >= esv_pkg::EXC_RSV_B_LO && n <= esv_pkg::EXC_RSV_B_HI);
  endfunction

  function automatic logic signed [esv_pkg::SPRIO_W-1:0] eff_prio(
    input logic [esv_pkg::EXC_W-1:0] n,
    input logic [esv_pkg::NUM_EXC*esv_pkg::PRIO_W-1:0] pr);
    case (n)
      esv_pkg::EXC_RESET: return esv_pkg::PRIO_RESET;
      esv_pkg::EXC_NMI: return esv_pkg::PRIO_NMI;
      esv_pkg::EXC_HARD: return esv_pkg::PRIO_HARD;
      default: return {2'b00, pr[{n, 2'b00} +: esv_pkg::PRIO_W]};
    endcase
  endfunction

  function automatic logic [31:0] vec_addr(input logic [esv_pkg::EXC_W-1:0] n);
    return esv_pkg::VEC_BASE + {23'h000000, n, 2'b00};
  endfunction

  esv_pkg::esv_rst_t rst_state;
  logic [esv_pkg::EXC_W-1:0] stack [0:esv_pkg::STACK_DEPTH-1];
  logic [esv_pkg::PTR_W-1:0] depth;
  logic [esv_pkg::NUM_EXC-1:0] set_vec;
  logic [esv_pkg::NUM_EXC-1:0] en_eff;
  logic [esv_pkg::NUM_EXC-1:0] take_hot;
  logic [esv_pkg::NUM_EXC-1:0] ret_hot;
  logic [esv_pkg::EXC_W-1:0] top_num;
  logic [esv_pkg::EXC_W-1:0] below_num;
  logic signed [esv_pkg::SPRIO_W-1:0] run_prio;
  logic [esv_pkg::EXC_W-1:0] best_num;
  logic signed [esv_pkg::SPRIO_W-1:0] best_prio;
  logic best_valid;
  logic take_ok;
  logic do_ret;
  logic usage_evt;
  logic hard_evt;

  // event sources to exception numbers
  always_comb begin
    set_vec = '0;
    usage_evt = i_undef_instr | i_illegal_unaligned | i_invalid_state |
                i_exc_return_err;
    usage_evt = usage_evt | (i_trap_unaligned_cfg & i_unaligned_access) |
                (i_trap_div0_cfg & i_div_by_zero);
    // a disabled fault handler escalates to hard fault
    hard_evt = i_exc_proc_err;
    if (i_exc_enable[esv_pkg::EXC_MEM]) begin
      set_vec[esv_pkg::EXC_MEM] = i_mpu_violation;
    end else begin
      hard_evt = hard_evt | i_mpu_violation;
    end
    if (i_exc_enable[esv_pkg::EXC_BUS]) begin
      set_vec[esv_pkg::EXC_BUS] = i_bus_err_precise | i_bus_err_imprecise;
    end else begin
      hard_evt = hard_evt | i_bus_err_precise | i_bus_err_imprecise;
    end
    if (i_exc_enable[esv_pkg::EXC_USAGE]) begin
      set_vec[esv_pkg::EXC_USAGE] = usage_evt;
    end else begin
      hard_evt = hard_evt | usage_evt;
    end
    set_vec[esv_pkg::EXC_HARD] = hard_evt;
    set_vec[esv_pkg::EXC_NMI] = i_nmi_req | i_nmi_sw_set;
    set_vec[esv_pkg::EXC_SVC] = i_svc_exec;
    set_vec[esv_pkg::EXC_DSR] = i_dsr_sw_set;
    set_vec[esv_pkg::EXC_TICK] = i_tick_zero | i_tick_sw_set;
    set_vec[esv_pkg::EXC_IRQ0 +: esv_pkg::NUM_IRQ] = i_irq_req | i_irq_sw_set;
  end

  // reset, nmi and hard fault ignore the enable
  always_comb begin
    en_eff = i_exc_enable;
    en_eff[esv_pkg::EXC_RESET] = 1'b1;
    en_eff[esv_pkg::EXC_NMI] = 1'b1;
    en_eff[esv_pkg::EXC_HARD] = 1'b1;
  end

  // pick the most urgent eligible pending exception
  always_comb begin
    best_num = esv_pkg::EXC_NONE;
    best_prio = esv_pkg::PRIO_THREAD;
    best_valid = 1'b0;
    for (int n = 1; n < esv_pkg::NUM_EXC; n++) begin
      if (o_pending[n] && en_eff[n] && !o_active[n] &&
          !is_reserved(n[esv_pkg::EXC_W-1:0]) &&
          (!best_valid ||
           eff_prio(n[esv_pkg::EXC_W-1:0], i_exc_prio) < best_prio)) begin
        best_num = n[esv_pkg::EXC_W-1:0];
        best_prio = eff_prio(n[esv_pkg::EXC_W-1:0], i_exc_prio);
        best_valid = 1'b1;
      end
    end
  end

  assign top_num = (depth != '0) ? stack[depth - 5'h01] : esv_pkg::EXC_NONE;
  assign below_num = (depth > 5'h01) ? stack[depth - 5'h02] : esv_pkg::EXC_NONE;
  assign run_prio = (depth != '0) ? eff_prio(top_num, i_exc_prio) : esv_pkg::PRIO_THREAD;
  assign do_ret = i_exc_return && (depth != '0) && (rst_state == esv_pkg::RS_RUN);
  // entry only at an instruction boundary, so one more instruction may retire
  assign take_ok = best_valid && (best_prio < run_prio) && i_instr_boundary &&
                   !i_exc_return && (rst_state == esv_pkg::RS_RUN) &&
                   (depth != esv_pkg::STACK_DEPTH[esv_pkg::PTR_W-1:0]);

  always_comb begin
    take_hot = '0;
    ret_hot = '0;
    if (take_ok) begin
      take_hot[best_num] = 1'b1;
    end
    if (do_ret) begin
      ret_hot[top_num] = 1'b1;
    end
  end

  // reset sequencing
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rst_state <= esv_pkg::RS_HALT;
      o_halt <= 1'b1;
      o_thread_priv <= 1'b0;
    end else begin
      rst_state <= esv_pkg::RS_RUN;
      o_halt <= 1'b0;
      o_thread_priv <= (rst_state == esv_pkg::RS_HALT) ? 1'b1 : o_thread_priv;
    end
  end

  // pending state: a new request wins over the clear on entry
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pending <= '0;
    end else begin
      o_pending <= (o_pending & ~take_hot) | set_vec;
    end
  end

  // active state; earlier handlers stay active while nested
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_active <= '0;
    end else begin
      o_active <= (o_active | take_hot) & ~ret_hot;
    end
  end

  // nesting stack of active exception numbers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      depth <= '0;
      for (int i = 0; i < esv_pkg::STACK_DEPTH; i++) begin
        stack[i] <= esv_pkg::EXC_NONE;
      end
    end else if (take_ok) begin
      stack[depth] <= best_num;
      depth <= depth + 5'h01;
    end else if (do_ret) begin
      depth <= depth - 5'h01;
    end
  end

  // entry request, vector address and active number
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_take <= 1'b0;
      o_take_num <= esv_pkg::EXC_NONE;
      o_vector_addr <= '0;
      o_active_num <= '0;
    end else if (rst_state == esv_pkg::RS_HALT) begin
      o_take <= 1'b1;
      o_take_num <= esv_pkg::EXC_RESET;
      o_vector_addr <= esv_pkg::VEC_RESET;
      o_active_num <= '0;
    end else if (take_ok) begin
      o_take <= 1'b1;
      o_take_num <= best_num;
      o_vector_addr <= vec_addr(best_num);
      o_active_num <= {2'b00, best_num};
    end else begin
      o_take <= 1'b0;
      if (do_ret) begin
        o_active_num <= {2'b00, below_num};
      end
    end
  end

  property p_halt;
    @(posedge i_core_clk) i_reset |=> o_halt && !o_take;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not raised under reset");

  property p_reset_fetch;
    @(posedge i_core_clk) disable iff (i_reset)
      $past(i_reset) |=> o_take && o_take_num == esv_pkg::EXC_RESET &&
                         o_vector_addr == esv_pkg::VEC_RESET && o_thread_priv;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("no reset vector fetch");

  property p_vec;
    @(posedge i_core_clk) disable iff (i_reset)
      o_take |-> o_vector_addr == esv_pkg::VEC_BASE + {23'h000000, o_take_num, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("vector address mismatch");

  property p_no_rsv;
    @(posedge i_core_clk) disable iff (i_reset) o_take |-> !is_reserved(o_take_num);
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved exception taken");

  property p_irq_pend;
    @(posedge i_core_clk) disable iff (i_reset)
      i_irq_req[0] |=> o_pending[esv_pkg::EXC_IRQ0];
  endproperty
  a_irq_pend: assert property (p_irq_pend) else $error("interrupt request lost");

  property p_act_pend;
    @(posedge i_core_clk) disable iff (i_reset)
      o_active[esv_pkg::EXC_IRQ0] && i_irq_sw_set[0] && !i_exc_return |=>
        o_active[esv_pkg::EXC_IRQ0] && o_pending[esv_pkg::EXC_IRQ0];
  endproperty
  a_act_pend: assert property (p_act_pend) else $error("not active and pending");

  property p_nest;
    @(posedge i_core_clk) disable iff (i_reset)
      take_ok && depth != '0 |=> (($past(o_active) & ~o_active) == '0) &&
                                 depth == $past(depth) + 5'h01;
  endproperty
  a_nest: assert property (p_nest) else $error("nested handler lost active");

  property p_preempt;
    @(posedge i_core_clk) disable iff (i_reset)
      o_take && o_take_num != esv_pkg::EXC_RESET |->
        eff_prio(o_take_num, $past(i_exc_prio)) < $past(run_prio);
  endproperty
  a_preempt: assert property (p_preempt) else $error("entry without higher priority");

  property p_nmi_safe;
    @(posedge i_core_clk) disable iff (i_reset)
      top_num == esv_pkg::EXC_NMI |=> !o_take || o_take_num == esv_pkg::EXC_RESET;
  endproperty
  a_nmi_safe: assert property (p_nmi_safe) else $error("nmi handler preempted");

  property p_active_num;
    @(posedge i_core_clk) disable iff (i_reset)
      o_take && o_take_num != esv_pkg::EXC_RESET |-> o_active_num == {2'b00, o_take_num};
  endproperty
  a_active_num: assert property (p_active_num) else $error("active number wrong");

  // entry only where the core said it can take one
  property p_boundary;
    @(posedge i_core_clk) disable iff (i_reset)
      o_take && o_take_num != esv_pkg::EXC_RESET |-> $past(i_instr_boundary);
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry off instruction boundary");

  // configurable exceptions are entered only while enabled
  property p_enabled;
    @(posedge i_core_clk) disable iff (i_reset)
      take_ok && best_num > esv_pkg::EXC_HARD |-> i_exc_enable[best_num];
  endproperty
  a_enabled: assert property (p_enabled) else $error("disabled exception entered");

  c_nested: cover property (@(posedge i_core_clk) disable iff (i_reset)
    take_ok && depth != '0);
  c_nmi: cover property (@(posedge i_core_clk) disable iff (i_reset)
    o_take && o_take_num == esv_pkg::EXC_NMI);
  c_act_pend: cover property (@(posedge i_core_clk) disable iff (i_reset)
    o_active[esv_pkg::EXC_IRQ0] && o_pending[esv_pkg::EXC_IRQ0]);
  c_return: cover property (@(posedge i_core_clk) disable iff (i_reset) do_ret);

endmodule // esv_exception_unit

// ### src/esv_pkg.sv
/*
  esv_pkg: constants and types shared by the exception state and vector unit.
  Assumes a 10 MHz core clock and a synchronous active-high reset.
*/
package esv_pkg;
  // table sizes
  localparam int NUM_EXC = 84;
  localparam int NUM_IRQ = 68;
  localparam int EXC_W = 7;
  localparam int PRIO_W = 4;
  localparam int SPRIO_W = 6;
  localparam int ACT_W = 9;
  localparam int STACK_DEPTH = 20;
  localparam int PTR_W = 5;

  // exception numbers
  localparam logic [EXC_W-1:0] EXC_NONE = 7'h00;
  localparam logic [EXC_W-1:0] EXC_RESET = 7'h01;
  localparam logic [EXC_W-1:0] EXC_NMI = 7'h02;
  localparam logic [EXC_W-1:0] EXC_HARD = 7'h03;
  localparam logic [EXC_W-1:0] EXC_MEM = 7'h04;
  localparam logic [EXC_W-1:0] EXC_BUS = 7'h05;
  localparam logic [EXC_W-1:0] EXC_USAGE = 7'h06;
  localparam logic [EXC_W-1:0] EXC_RSV_A_LO = 7'h07;
  localparam logic [EXC_W-1:0] EXC_RSV_A_HI = 7'h0a;
  localparam logic [EXC_W-1:0] EXC_SVC = 7'h0b;
  localparam logic [EXC_W-1:0] EXC_RSV_B_LO = 7'h0c;
  localparam logic [EXC_W-1:0] EXC_RSV_B_HI = 7'h0d;
  localparam logic [EXC_W-1:0] EXC_DSR = 7'h0e;
  localparam logic [EXC_W-1:0] EXC_TICK = 7'h0f;
  localparam logic [EXC_W-1:0] EXC_IRQ0 = 7'h10;
  localparam logic [EXC_W-1:0] EXC_LAST = 7'h53;

  // fixed priorities, signed; thread level sits below every configurable value
  localparam logic signed [SPRIO_W-1:0] PRIO_RESET = 6'sh3d;
  localparam logic signed [SPRIO_W-1:0] PRIO_NMI = 6'sh3e;
  localparam logic signed [SPRIO_W-1:0] PRIO_HARD = 6'sh3f;
  localparam logic signed [SPRIO_W-1:0] PRIO_THREAD = 6'sh10;

  // vector table
  localparam logic [31:0] VEC_BASE = 32'h0000_0000;
  localparam logic [31:0] VEC_RESET = 32'h0000_0004;

  typedef enum logic [0:0] {
    RS_HALT,
    RS_RUN
  } esv_rst_t;
endpackage

// ### bench/esv_irq_source.sv
/*
  esv_irq_source: model of the peripherals and software that raise requests.
  Assumes one i_go pulse per request, driven just after a rising edge.
*/
`timescale 1ns/1ns
module esv_irq_source (
  // clock and command
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic i_sw,
  input wire logic [6:0] i_num,
  // requests towards the core
  output logic [esv_pkg::NUM_IRQ-1:0] o_irq_req,
  output logic [esv_pkg::NUM_IRQ-1:0] o_irq_sw_set,
  output logic o_nmi_req
);
  // one-cycle pulses; released lines drop back to idle low
  always_ff @(posedge i_core_clk) begin
    o_irq_req <= '0;
    o_irq_sw_set <= '0;
    o_nmi_req <= i_go && (i_num == 7'h7f);
    if (i_go && i_num < 7'h44) begin
      if (i_sw) o_irq_sw_set[i_num] <= 1'b1;
      else o_irq_req[i_num] <= 1'b1;
    end
  end
endmodule // esv_irq_source

// ### bench/esv_exception_unit_bench.sv
/*
  esv_exception_unit_bench: self-checking bench for the exception unit.
  Assumes a 10 MHz clock and the source model in esv_irq_source.
*/
`timescale 1ns/1ns
module esv_exception_unit_bench;
  logic i_core_clk, i_reset, p_go, p_sw, tc_un, tc_dz, i_exc_return, bnd;
  logic [6:0] p_num;
  logic [14:0] ev;
  logic [esv_pkg::NUM_IRQ-1:0] irq_hw, irq_sw;
  logic nmi_hw;
  logic [esv_pkg::NUM_EXC-1:0] en, o_pending, o_active;
  logic [esv_pkg::NUM_EXC*esv_pkg::PRIO_W-1:0] prio;
  logic o_halt, o_thread_priv, o_take;
  logic [6:0] o_take_num;
  logic [31:0] o_vector_addr;
  logic [8:0] o_active_num;
  int failures, n_checks;
  // exception expected for each fault or system event line
  localparam logic [6:0] EVN [15] = '{7'h03, 7'h04, 7'h05, 7'h05, 7'h06,
    7'h06, 7'h06, 7'h06, 7'h06, 7'h06, 7'h0b, 7'h0e, 7'h0f, 7'h0f, 7'h02};

  esv_irq_source u_esv_irq_source (.i_core_clk(i_core_clk), .i_go(p_go),
    .i_sw(p_sw), .i_num(p_num), .o_irq_req(irq_hw), .o_irq_sw_set(irq_sw),
    .o_nmi_req(nmi_hw));

  esv_exception_unit u_esv_exception_unit (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_irq_req(irq_hw), .i_irq_sw_set(irq_sw),
    .i_nmi_req(nmi_hw), .i_nmi_sw_set(ev[14]), .i_dsr_sw_set(ev[11]),
    .i_tick_zero(ev[12]), .i_tick_sw_set(ev[13]), .i_svc_exec(ev[10]),
    .i_exc_proc_err(ev[0]), .i_mpu_violation(ev[1]),
    .i_bus_err_precise(ev[2]), .i_bus_err_imprecise(ev[3]),
    .i_undef_instr(ev[4]), .i_illegal_unaligned(ev[5]),
    .i_invalid_state(ev[6]), .i_exc_return_err(ev[7]),
    .i_unaligned_access(ev[8]), .i_div_by_zero(ev[9]),
    .i_trap_unaligned_cfg(tc_un), .i_trap_div0_cfg(tc_dz),
    .i_exc_enable(en), .i_exc_prio(prio), .i_instr_boundary(bnd),
    .i_exc_return(i_exc_return), .o_halt(o_halt),
    .o_thread_priv(o_thread_priv), .o_take(o_take),
    .o_take_num(o_take_num), .o_vector_addr(o_vector_addr),
    .o_active_num(o_active_num), .o_pending(o_pending),
    .o_active(o_active));

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic fire(input int i);
    @(posedge i_core_clk) ev[i] <= 1'b1;
    @(posedge i_core_clk) ev[i] <= 1'b0;
    #1;
  endtask

  task automatic go(input logic [6:0] n, input logic sw);
    @(posedge i_core_clk);
    p_go <= 1'b1;
    p_num <= n;
    p_sw <= sw;
    @(posedge i_core_clk) p_go <= 1'b0;
    #1;
  endtask

  task automatic ret();
    @(posedge i_core_clk) i_exc_return <= 1'b1;
    @(posedge i_core_clk) i_exc_return <= 1'b0;
    #1;
  endtask

  // bounded wait for an entry, then judge number and vector
  task automatic take(input logic [6:0] n);
    int k;
    k = 0;
    while (o_take !== 1'b1 && k < 6) begin
      cyc(1);
      k++;
    end
    chk(o_take, 1'b1);
    chk(o_take_num, n);
    chk(o_vector_addr, {23'h0, n, 2'b00});
    chk(o_active_num, {2'b00, n});
    chk(o_active[n], 1'b1);
  endtask

  task automatic t_reset();
    chk(o_halt, 1'b1);
    chk(o_pending[31:0], 32'h0);
    @(posedge i_core_clk) i_reset <= 1'b0;
    cyc(1);
    chk({o_take, o_take_num, o_halt}, {1'b1, 7'h01, 1'b0});
    chk(o_vector_addr, 32'h0000_0004);
    chk(o_thread_priv, 1'b1);
    cyc(1);
    $display("reset done");
  endtask

  task automatic t_irq();
    go(7'h00, 1'b0);
    take(7'h10);
    chk(o_pending[16], 1'b0);
    go(7'h00, 1'b1);
    cyc(1);
    chk({o_pending[16], o_active[16]}, 2'b11);
    ret();
    take(7'h10);
    ret();
    chk(o_active_num, 9'h000);
    @(posedge i_core_clk) bnd <= 1'b0;
    go(7'h43, 1'b1);
    cyc(3);
    chk({o_pending[83], o_active[83]}, 2'b10);
    @(posedge i_core_clk) bnd <= 1'b1;
    take(7'h53);
    ret();
    $display("irq map done");
  endtask

  task automatic t_nest();
    @(posedge i_core_clk);
    prio[84+:4] <= 4'h8;
    prio[88+:4] <= 4'h2;
    prio[92+:4] <= 4'h2;
    go(7'h05, 1'b0);
    take(7'h15);
    go(7'h05, 1'b1);
    cyc(3);
    chk({o_pending[21], o_active[21]}, 2'b11);
    go(7'h06, 1'b0);
    take(7'h16);
    chk(o_active[21], 1'b1);
    go(7'h07, 1'b0);
    cyc(4);
    chk({o_pending[23], o_active_num}, {1'b1, 9'h016});
    ret();
    take(7'h17);
    ret();
    chk(o_active_num, 9'h015);
    ret();
    take(7'h15);
    ret();
    $display("nesting done");
  endtask

  task automatic t_tie();
    @(posedge i_core_clk) en[25:24] <= 2'b00;
    go(7'h09, 1'b0);
    go(7'h08, 1'b1);
    cyc(3);
    chk({o_pending[25:24], o_active_num}, {2'b11, 9'h000});
    @(posedge i_core_clk) en[25:24] <= 2'b11;
    take(7'h18);
    ret();
    take(7'h19);
    ret();
    $display("tie done");
  endtask

  task automatic t_nmi();
    @(posedge i_core_clk) en <= '0;
    go(7'h7f, 1'b0);
    take(7'h02);
    fire(0);
    cyc(3);
    chk({o_pending[3], o_active_num}, {1'b1, 9'h002});
    ret();
    take(7'h03);
    ret();
    @(posedge i_core_clk) en <= '1;
    $display("nmi done");
  endtask

  task automatic t_faults();
    @(posedge i_core_clk);
    tc_un <= 1'b1;
    tc_dz <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      fire(i);
      take(EVN[i]);
      ret();
    end
    @(posedge i_core_clk);
    tc_un <= 1'b0;
    tc_dz <= 1'b0;
    fire(8);
    fire(9);
    cyc(3);
    chk({o_pending[6], o_active[6]}, 2'b00);
    @(posedge i_core_clk) en[4] <= 1'b0;
    fire(1);
    take(7'h03);
    ret();
    @(posedge i_core_clk) en[4] <= 1'b1;
    $display("faults done");
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    failures++;
    stop_test();
  end

  initial begin
    failures = 0;
    n_checks = 0;
    i_reset = 1'b1;
    {p_go, p_sw, tc_un, tc_dz, i_exc_return} = 5'h00;
    bnd = 1'b1;
    p_num = 7'h00;
    ev = '0;
    en = '1;
    prio = '0;
    repeat (4) @(posedge i_core_clk);
    #1;
    t_reset();
    t_irq();
    t_nest();
    t_tie();
    t_nmi();
    t_faults();
    stop_test();
  end
endmodule // esv_exception_unit_bench
